//--- core/divn_synth.sv
// Programmable divide-by-N chain, phase comparator and AXI4-Lite registers
//
// Contract
// RQ1: Halve oscillator before the divide-by-N chain
// RQ2: Phase comparator against decade-divided reference
// RQ3: Host programs N as 9's complement BCD
// RQ4: Upper byte captured on upper strobe
// RQ5: MSD sent as one bit on bit 4
// RQ6: Digit three in upper nibble, lower byte follows (code takes digit three from bits 3:0 of the upper byte)
// RQ7: Lower strobe sets flop; next edge clears it
// RQ8: Following edge copies held N to working
// RQ9: Active-low check bit captured from bit 7
// RQ10: Check low enables extra divide-by-two output
// RQ11: Check mode digits hold nine, MSD zero
// RQ12: Check high inhibits check output
// RQ13: Prescaler P+1 until D expires, then P
// RQ14: Np keeps counting, emits output pulse
// RQ15: P ten gives ratio equal to ABCD
// RQ16: Output pulse reloads the next cycle
// RQ17: Np must exceed D
// RQ18: Decades preload nine minus digit, carry at nine
// RQ19: Check mode presets D stage to nine
// RQ20: Load low for two input periods
// RQ21: Load low inhibits and presets all stages
// RQ22: Decode 997 to end the Np chain
// RQ23: Working N changes only on transfer edge
//
// Local design decisions: the AXI4-Lite register port and the address map.
`default_nettype none
module divn_synth (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic osc_i,
    input wire logic xfer_clk_i,
    input wire logic ref_in_i,
    output logic phase_error_a_o,
    output logic phase_error_b_o,
    output logic div_out_o,
    output logic check_o,
    input wire logic [divn_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [divn_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import divn_pkg::*;

    // Bus write path
    logic aw_have_q;
    logic w_have_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [7:0] wbyte_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic wr_go;
    logic upper_byte_strobe;
    logic lower_byte_strobe;

    assign s_axi_awready = !aw_have_q && !bvalid_q;
    assign s_axi_wready = !w_have_q && !bvalid_q;
    assign wr_go = aw_have_q && w_have_q && !bvalid_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_have_q <= 1'b0;
            awaddr_q <= UPPER_OFFS;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            w_have_q <= 1'b0;
            wbyte_q <= 8'h00;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wbyte_q <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
        end else if (wr_go) begin
            w_have_q <= 1'b0;
        end
    end

    assign upper_byte_strobe = wr_go && (awaddr_q == UPPER_OFFS);
    assign lower_byte_strobe = wr_go && (awaddr_q == LOWER_OFFS);

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid_q <= 1'b1;
            bresp_q <= (upper_byte_strobe || lower_byte_strobe) ?
                       RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // Holding registers
    logic check_n_q;
    logic msd_hold_q;
    logic [3:0] dig3_hold_q;
    logic [3:0] dig2_hold_q;
    logic [3:0] dig1_hold_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            check_n_q <= RST_CHECK_N;
            msd_hold_q <= RST_MSD;
            dig3_hold_q <= RST_DIGIT;
        end else if (upper_byte_strobe) begin // RQ4
            check_n_q <= wbyte_q[CHECK_BIT]; // RQ9
            msd_hold_q <= wbyte_q[MSD_BIT]; // RQ5
            dig3_hold_q <= wbyte_q[NIB_LO:0]; // RQ6
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dig2_hold_q <= RST_DIGIT;
            dig1_hold_q <= RST_DIGIT;
        end else if (lower_byte_strobe) begin
            dig2_hold_q <= wbyte_q[NIB_HI:NIB_LO+1]; // RQ6
            dig1_hold_q <= wbyte_q[NIB_LO:0];
        end
    end

    // Transfer sequence on the transfer clock
    logic xfer_clk_prev_q;
    logic xfer_rise;
    logic xfer_a_q;
    logic xfer_b_q;
    logic xfer_load;

    assign xfer_rise = xfer_clk_i && !xfer_clk_prev_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            xfer_clk_prev_q <= 1'b0;
        end else begin
            xfer_clk_prev_q <= xfer_clk_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            xfer_a_q <= 1'b0;
        end else if (lower_byte_strobe) begin
            xfer_a_q <= 1'b1; // RQ7
        end else if (!xfer_b_q) begin
            xfer_a_q <= 1'b0; // RQ7
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            xfer_b_q <= 1'b1;
        end else if (xfer_rise) begin
            xfer_b_q <= !xfer_a_q; // RQ7 RQ8
        end
    end

    assign xfer_load = xfer_rise && !xfer_b_q && xfer_a_q == 1'b0;

    // Working registers
    logic msd_q;
    logic [3:0] dig3_q;
    logic [3:0] dig2_q;
    logic [3:0] dig1_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            msd_q <= RST_MSD;
            dig3_q <= RST_DIGIT;
            dig2_q <= RST_DIGIT;
            dig1_q <= RST_DIGIT;
        end else if (xfer_load) begin // RQ8 RQ23
            msd_q <= msd_hold_q;
            dig3_q <= dig3_hold_q;
            dig2_q <= dig2_hold_q;
            dig1_q <= dig1_hold_q;
        end
    end

    // First halving stage
    logic osc_prev_q;
    logic half_q;
    logic f1;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            osc_prev_q <= 1'b0;
            half_q <= 1'b0;
        end else begin
            osc_prev_q <= osc_i;
            if (osc_i && !osc_prev_q) begin
                half_q <= !half_q; // RQ1
            end
        end
    end

    assign f1 = osc_i && !osc_prev_q && half_q; // RQ1

    // Check output: extra halving of f1
    logic check_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            check_q <= 1'b0;
        end else if (check_n_q) begin
            check_q <= 1'b0; // RQ12
        end else if (f1) begin
            check_q <= !check_q; // RQ10
        end
    end

    assign check_o = check_q;

    // Load window
    logic load_n_q;
    logic [1:0] load_cnt_q;
    logic fout;
    logic pre_pulse;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            load_n_q <= 1'b0;
            load_cnt_q <= 2'h0;
        end else if (fout) begin
            load_n_q <= 1'b0; // RQ16 RQ20
            load_cnt_q <= 2'h0;
        end else if (!load_n_q && pre_pulse) begin
            if (load_cnt_q == LOAD_LAST) begin
                load_n_q <= 1'b1; // RQ20
            end
            load_cnt_q <= load_cnt_q + 2'h1;
        end
    end

    // Two-modulus prescaler
    logic [3:0] pre_q;
    logic [3:0] pre_limit;
    logic scaler_ctrl;

    // Divide by P while loading: the two load periods stand in for the
    // two counts that the 997 end decode leaves out
    assign pre_limit = (scaler_ctrl || !load_n_q) ?
                       PRESCALE_P - 4'h1 : PRESCALE_P; // RQ13 RQ22
    assign pre_pulse = f1 && (pre_q == pre_limit);

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pre_q <= 4'h0;
        end else if (f1) begin
            pre_q <= pre_pulse ? 4'h0 : pre_q + 4'h1;
        end
    end

    // D stage and Np chain
    logic [3:0] d_preload;
    logic [3:0] a_preload;
    logic [3:0] c_count;
    logic [3:0] b_count;
    logic [3:0] a_count;
    logic c_carry;
    logic b_carry;
    logic a_carry;

    assign d_preload = check_n_q ? dig1_q : COMP9_ZERO; // RQ19 RQ11
    assign a_preload = {MSD_BASE, msd_q}; // RQ5

    decade_counter u_d_stage (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .load_n_i(load_n_q),
        .preload_i(d_preload), // RQ18
        .count_i(pre_pulse && !scaler_ctrl), // RQ13
        .count_o(),
        .carry_o(scaler_ctrl) // RQ13
    );

    decade_counter u_np_low (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .load_n_i(load_n_q),
        .preload_i(dig2_q),
        .count_i(pre_pulse), // RQ14
        .count_o(c_count),
        .carry_o(c_carry)
    );

    decade_counter u_np_mid (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .load_n_i(load_n_q),
        .preload_i(dig3_q),
        .count_i(pre_pulse && c_carry),
        .count_o(b_count),
        .carry_o(b_carry)
    );

    decade_counter u_np_high (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .load_n_i(load_n_q),
        .preload_i(a_preload),
        .count_i(pre_pulse && c_carry && b_carry),
        .count_o(a_count),
        .carry_o(a_carry)
    );

    // End of cycle decode at 997
    assign fout = load_n_q && a_carry && b_carry &&
                  (c_count == NP_END_DIGIT); // RQ22 RQ14 RQ15

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_out_o <= 1'b1;
        end else begin
            div_out_o <= !fout; // RQ22
        end
    end

    // Reference decade divider
    logic ref_prev_q;
    logic ref_rise;
    logic ref_carry;
    logic ref_pulse;

    assign ref_rise = ref_in_i && !ref_prev_q;
    assign ref_pulse = ref_rise && ref_carry;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_prev_q <= 1'b0;
        end else begin
            ref_prev_q <= ref_in_i;
        end
    end

    decade_counter u_ref_div (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .load_n_i(1'b1),
        .preload_i(DIGIT_ZERO),
        .count_i(ref_rise), // RQ2
        .count_o(),
        .carry_o(ref_carry)
    );

    // Phase comparator
    logic err_a_q;
    logic err_b_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            err_a_q <= 1'b0;
            err_b_q <= 1'b0;
        end else if ((err_a_q || ref_pulse) && (err_b_q || fout)) begin
            err_a_q <= 1'b0; // RQ2
            err_b_q <= 1'b0;
        end else begin
            err_a_q <= err_a_q || ref_pulse; // RQ2
            err_b_q <= err_b_q || fout;
        end
    end

    assign phase_error_a_o = err_a_q;
    assign phase_error_b_o = err_b_q;

    // Bus read path
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;

    assign s_axi_arready = !rvalid_q;

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h00000000;
            case (s_axi_araddr)
                UPPER_OFFS: begin
                    rdata_q[7:0] <= {check_n_q, 2'h0, msd_hold_q,
                                     dig3_hold_q};
                end
                LOWER_OFFS: begin
                    rdata_q[7:0] <= {dig2_hold_q, dig1_hold_q};
                end
                STATUS_OFFS: begin
                    rdata_q[15:0] <= {3'h0, msd_q, dig3_q, dig2_q, dig1_q};
                    rdata_q[STATUS_CTRL] <= scaler_ctrl;
                    rdata_q[STATUS_XFER] <= xfer_a_q || !xfer_b_q;
                    rdata_q[STATUS_ERR_A] <= err_a_q;
                    rdata_q[STATUS_ERR_B] <= err_b_q;
                end
                default: begin
                    rresp_q <= RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule
`default_nettype wire

//--- core/divn_pkg.sv
// Package of constants for the programmable divide-by-N synthesiser block
`default_nettype none
package divn_pkg;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] UPPER_OFFS = 4'h0;
    localparam logic [ADDR_W-1:0] LOWER_OFFS = 4'h4;
    localparam logic [ADDR_W-1:0] STATUS_OFFS = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int CHECK_BIT = 7;
    localparam int MSD_BIT = 4;
    localparam int NIB_HI = 7;
    localparam int NIB_LO = 3;
    localparam logic [3:0] DIGIT_MAX = 4'h9;
    localparam logic [3:0] DIGIT_ZERO = 4'h0;
    localparam logic [3:0] NP_END_DIGIT = 4'h7;
    localparam logic [2:0] MSD_BASE = 3'h3;
    localparam logic [3:0] PRESCALE_P = 4'hA;
    localparam logic [3:0] COMP9_ZERO = 4'h9;
    localparam logic [3:0] RST_DIGIT = 4'h9;
    localparam logic RST_MSD = 1'b0;
    localparam logic RST_CHECK_N = 1'b1;
    localparam logic [1:0] LOAD_LAST = 2'h1;
    localparam int STATUS_CTRL = 16;
    localparam int STATUS_XFER = 17;
    localparam int STATUS_ERR_A = 18;
    localparam int STATUS_ERR_B = 19;
endpackage
`default_nettype wire

//--- core/decade_counter.sv
// Presettable decade up-counter with carry at nine
`default_nettype none
module decade_counter (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic load_n_i,
    input wire logic [3:0] preload_i,
    input wire logic count_i,
    output logic [3:0] count_o,
    output logic carry_o
);
    import divn_pkg::*;

    logic [3:0] count_q;

    // Preload forces the stage, otherwise wrap after nine
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            count_q <= DIGIT_ZERO;
        end else if (!load_n_i) begin
            count_q <= preload_i; // RQ21
        end else if (count_i) begin
            if (count_q == DIGIT_MAX) begin
                count_q <= DIGIT_ZERO; // RQ18
            end else begin
                count_q <= count_q + 4'h1;
            end
        end
    end

    assign count_o = count_q;
    assign carry_o = (count_q == DIGIT_MAX); // RQ18
endmodule
`default_nettype wire

//--- testbench/axi_host.sv
// Host processor model driving the register bus of the divider block
`default_nettype none
module axi_host (
    input wire logic ref_clk_i,
    output logic [divn_pkg::ADDR_W-1:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [divn_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 100ps;
    import divn_pkg::*;

    initial begin
        s_axi_awaddr = '0;
        s_axi_awvalid = 1'b0;
        s_axi_wdata = 32'h0;
        s_axi_wstrb = 4'hF;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_araddr = '0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
    end

    // One byte per write; upper byte before lower byte is the caller's job
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] v,
                      output logic [1:0] resp);
        @(posedge ref_clk_i);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] v,
                      output logic [1:0] resp);
        @(posedge ref_clk_i);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge ref_clk_i);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

//--- testbench/divn_synth_asserts.sv
// Concurrent checks on the divider block ports
`default_nettype none
module divn_synth_chk (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic div_out_o,
    input wire logic check_o,
    input wire logic phase_error_a_o,
    input wire logic phase_error_b_o,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence load_quiet_s;
        div_out_o [*8];
    endsequence
    sequence both_taken_s;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    a_load_window: assert property ($fell(div_out_o) |=> load_quiet_s)
        else $error("divider pulse not followed by load window");
    a_check_low: assert property ($fell(check_o) |-> !check_o [*4])
        else $error("check output low phase too short");
    a_phase_excl: assert property (!(phase_error_a_o && phase_error_b_o))
        else $error("both phase errors high");
    a_b_refuse: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address accepted during response");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_b_answer: assert property (both_taken_s |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_r_answer: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
endmodule

bind divn_synth divn_synth_chk u_chk (.ref_clk_i, .rst_n_i, .div_out_o,
    .check_o, .phase_error_a_o, .phase_error_b_o, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

//--- testbench/divn_synth_tb.sv
// Self-checking bench for the programmable divide-by-N block
`default_nettype none
module divn_synth_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import divn_pkg::*;
    logic ref_clk_i, rst_n_i, osc_i, xfer_clk_i, ref_in_i, sel_div;
    logic phase_error_a_o, phase_error_b_o, div_out_o, check_o;
    logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [2:0] ref_div;
    int bad_count, n_compared, n;
    wire logic mon = sel_div ? ~div_out_o : check_o;

    divn_synth u_dut (.ref_clk_i, .rst_n_i, .osc_i, .xfer_clk_i, .ref_in_i,
        .phase_error_a_o, .phase_error_b_o, .div_out_o, .check_o,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);
    axi_host u_host (.ref_clk_i, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    initial begin
        ref_clk_i = 1'b0;
        forever begin
            #12.5 ref_clk_i = ~ref_clk_i;
        end
    end

    // Oscillator rises every second cycle, reference every eighth
    always @(posedge ref_clk_i) begin
        osc_i <= ~osc_i;
        ref_div <= ref_div + 3'h1;
        ref_in_i <= ref_div[2];
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic stat(input logic [31:0] exp);
        u_host.rd(STATUS_OFFS, d, r);
        chk(d & 32'h0002FFFF, exp);
    endtask

    // Two rising edges of the transfer clock, idle otherwise
    task automatic xfer;
        repeat (2) begin
            @(posedge ref_clk_i);
            xfer_clk_i <= 1'b1;
            repeat (4) @(posedge ref_clk_i);
            xfer_clk_i <= 1'b0;
            repeat (4) @(posedge ref_clk_i);
        end
    endtask

    // Cycles until the next rise of check_o, or the next fall of div_out_o when sel_div is set
    task automatic rise_gap(output int cnt);
        logic p;
        cnt = 0;
        p = 1'b1;
        while (!(mon && !p) && cnt < 30000) begin
            p = mon;
            @(posedge ref_clk_i);
            cnt++;
        end
    endtask

    task automatic report_and_stop;
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        repeat (80000) @(posedge ref_clk_i);
        bad_count++;
        report_and_stop();
    end

    initial begin
        rst_n_i = 1'b0;
        osc_i = 1'b0;
        xfer_clk_i = 1'b0;
        ref_in_i = 1'b0;
        ref_div = 3'h0;
        sel_div = 1'b0;
        bad_count = 0;
        n_compared = 0;
        repeat (20) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        stat(32'h00000999);
        u_host.rd(UPPER_OFFS, d, r);
        chk(d & 32'h9F, 32'h89);
        u_host.wr(4'hC, 8'hFF, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        u_host.rd(4'hC, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        u_host.wr(UPPER_OFFS, 8'h09, r);
        u_host.wr(LOWER_OFFS, 8'h99, r);
        xfer();
        stat(32'h00000999);
        rise_gap(n);
        rise_gap(n);
        chk(n, 32'h8);
        u_host.wr(UPPER_OFFS, 8'h80, r);
        repeat (8) @(posedge ref_clk_i);
        chk({31'h0, check_o}, 32'h0);
        u_host.wr(LOWER_OFFS, 8'h01, r);
        stat(32'h00020999);
        u_host.rd(LOWER_OFFS, d, r);
        chk(d & 32'hFF, 32'h01);
        xfer();
        stat(32'h00000001);
        sel_div = 1'b1;
        rise_gap(n);
        rise_gap(n);
        // Ratio in halved-oscillator pulses is the 9's complement of the preload 6001
        chk(n, 4 * (9999 - 6001));
        // Divider pulse clears the comparator, a reference pulse sets A
        repeat (200) @(posedge ref_clk_i);
        chk({30'h0, phase_error_a_o, phase_error_b_o}, 32'h2);
        report_and_stop();
    end
endmodule
`default_nettype wire
